// file: shared/mfco_pkg.sv
package mfco_pkg;
   // register byte offsets
   localparam logic [4:0] MFCO_CFG_OFF = 5'h00;
   localparam logic [4:0] MFCO_CFG_CLR_OFF = 5'h04;
   localparam logic [4:0] MFCO_CFG_SET_OFF = 5'h08;
   localparam logic [4:0] MFCO_CFG_INV_OFF = 5'h0C;
   localparam logic [4:0] MFCO_STAT_OFF = 5'h10;
   // config word fields
   localparam int MFCO_DEFER_FOREVER_BIT = 14;
   localparam int MFCO_BP_SKIP_BIT = 13;
   localparam int MFCO_COL_SKIP_BIT = 12;
   localparam int MFCO_SHORT_PRE_BIT = 9;
   localparam int MFCO_PURE_PRE_BIT = 8;
   localparam int MFCO_AUTO_PAD_BIT = 7;
   localparam int MFCO_TAG_PAD_BIT = 6;
   localparam int MFCO_PAD_EN_BIT = 5;
   localparam logic [31:0] MFCO_CFG_RESET = 32'h0000_40B2;
   localparam logic [31:0] MFCO_CFG_MASK = 32'h0000_73FF;
   // status word fields
   localparam int MFCO_ST_ABORT_BIT = 0;
   localparam int MFCO_ST_RXDROP_BIT = 1;
   localparam int MFCO_ST_DEFER_BIT = 2;
   localparam int MFCO_ST_BACKOFF_BIT = 3;
   // receive preamble
   localparam logic [7:0] MFCO_PRE_OCTET = 8'h55;
   localparam logic [7:0] MFCO_SFD_OCTET = 8'hD5;
   localparam logic [3:0] MFCO_PRE_MAX_LEN = 4'hC;
   // transmit tagging and padding
   localparam logic [15:0] MFCO_TAG_ID = 16'h8100;
   localparam logic [4:0] MFCO_TYPE_POS = 5'h0C;
   localparam logic [6:0] MFCO_MIN_UNTAGGED = 7'h40;
   localparam logic [6:0] MFCO_MIN_TAGGED = 7'h44;
   // timing: one clock carries one nibble
   localparam int MFCO_SLOT_BITS = 512;
   localparam int MFCO_BITS_PER_CYC = 4;
   localparam int MFCO_SLOT_CYC = MFCO_SLOT_BITS / MFCO_BITS_PER_CYC;
   localparam int MFCO_BACKOFF_LIMIT = 10;
   localparam logic [15:0] MFCO_DEFER_LIMIT_CYC = 16'h0BDC;
   // transmit sequencer states
   typedef enum logic [3:0] {
      MFCO_TX_IDLE = 4'b0001,
      MFCO_TX_DEFER = 4'b0010,
      MFCO_TX_SEND = 4'b0100,
      MFCO_TX_BACKOFF = 4'b1000
   } mfco_tx_state_t;
endpackage

// file: rtl/mfco_rx_preamble.sv
`timescale 1ns/1ps
module mfco_rx_preamble
   import mfco_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic short_pre_en_i,
   input wire logic pure_pre_en_i,
   input wire logic rx_dv_i,
   input wire logic rx_er_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_accept_o,
   output logic rx_drop_o
);
   logic in_pre_q;
   logic active_q;
   logic bad_q;
   logic [3:0] cnt_q;
   logic long_pre;
   logic pre_fail;

   // verdict terms at the start-of-frame octet
   assign long_pre = short_pre_en_i && (cnt_q >= MFCO_PRE_MAX_LEN); // [RL4]
   assign pre_fail = pure_pre_en_i && (bad_q || rx_er_i); // [RL5]

   // preamble tracking and one-cycle verdict
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         in_pre_q <= 1'b0;
         active_q <= 1'b0;
         bad_q <= 1'b0;
         cnt_q <= 4'h0;
         rx_accept_o <= 1'b0;
         rx_drop_o <= 1'b0;
      end
      else
      begin
         rx_accept_o <= 1'b0;
         rx_drop_o <= 1'b0;
         active_q <= rx_dv_i;
         if (rx_dv_i && !active_q)
         begin
            in_pre_q <= (rx_data_i != MFCO_SFD_OCTET);
            cnt_q <= (rx_data_i != MFCO_SFD_OCTET) ? 4'h1 : 4'h0;
            bad_q <= (rx_data_i != MFCO_PRE_OCTET) && (rx_data_i != MFCO_SFD_OCTET)
                     || rx_er_i;
            if (rx_data_i == MFCO_SFD_OCTET)
            begin
               rx_accept_o <= !(pure_pre_en_i && rx_er_i);
               rx_drop_o <= pure_pre_en_i && rx_er_i;
            end
         end
         else if (rx_dv_i && in_pre_q)
         begin
            if (rx_data_i == MFCO_SFD_OCTET)
            begin
               in_pre_q <= 1'b0;
               rx_drop_o <= long_pre || pre_fail; // [RL4] [RL5]
               rx_accept_o <= !(long_pre || pre_fail);
            end
            else
            begin
               if (cnt_q != 4'hF)
               begin
                  cnt_q <= cnt_q + 4'h1;
               end
               if ((rx_data_i != MFCO_PRE_OCTET) || rx_er_i)
               begin
                  bad_q <= 1'b1; // [RL5]
               end
            end
         end
         else if (!rx_dv_i)
         begin
            in_pre_q <= 1'b0;
         end
      end
   end
endmodule

// file: rtl/mfco_top.sv
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Function
// RL1 - defer-forever set: wait out carrier, else abort
// RL2 - backpressure collision with skip bit: retransmit immediately
// RL3 - skip bit: no backoff; clear: exponential backoff
// RL4 - enforce: accept only preambles under twelve bytes
// RL5 - content check: octets 0x55, error-free, else discard
// RL6 - auto pad: compare type octets with 0x8100
// RL7 - pad enable clear disables auto and tagged pad
// RL8 - 16/32-bit accesses accepted, 8-bit ignored
// RL9 - unimplemented config bits read as zero
// RL10 - deferral abort reported in transmit status
module mfco_top
   import mfco_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // transmit control
   input wire logic tx_req_i,
   input wire logic tx_done_i,
   input wire logic carrier_i,
   input wire logic collision_i,
   input wire logic backpressure_i,
   output logic tx_go_o,
   output logic tx_abort_o,
   // transmit octet stream for tag detection
   input wire logic tx_byte_valid_i,
   input wire logic tx_first_i,
   input wire logic [7:0] tx_byte_i,
   output logic [6:0] pad_min_len_o,
   output logic pad_on_o,
   // receive octet stream
   input wire logic rx_dv_i,
   input wire logic rx_er_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_accept_o,
   output logic rx_drop_o
);
   import mfco_pkg::*;

   // lane mask: halfword or word only, bytes give none
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      case (sel)
         4'b0011: m = 32'h0000_FFFF;
         4'b1100: m = 32'hFFFF_0000;
         4'b1111: m = 32'hFFFF_FFFF;
         default: m = 32'h0000_0000;
      endcase
      return m;
   endfunction

   logic [31:0] cfg_q;
   logic [31:0] cfg_d;
   logic [31:0] stat_q;
   logic [31:0] wmask;
   logic req;
   logic wr;
   logic abort_set;
   logic rx_drop_int;
   logic rx_acc_int;
   mfco_tx_state_t st_q;
   logic [15:0] dcnt_q;
   logic [3:0] att_q;
   logic [9:0] slots_q;
   logic [7:0] scyc_q;
   logic [9:0] lfsr_q;
   logic [4:0] bcnt_q;
   logic [7:0] type_hi_q;
   logic tagged_q;
   logic skip_now;

   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i;
   assign wmask = lane_mask(sel_i) & MFCO_CFG_MASK; // [RL8] [RL9]

   // config write with clear, set and invert aliases
   always_comb
   begin
      cfg_d = cfg_q;
      if (wr)
      begin
         case (adr_i)
            MFCO_CFG_OFF: cfg_d = (cfg_q & ~wmask) | (dat_i & wmask);
            MFCO_CFG_CLR_OFF: cfg_d = cfg_q & ~(dat_i & wmask);
            MFCO_CFG_SET_OFF: cfg_d = cfg_q | (dat_i & wmask);
            MFCO_CFG_INV_OFF: cfg_d = cfg_q ^ (dat_i & wmask);
            default: cfg_d = cfg_q;
         endcase
      end
   end

   // config register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_q <= MFCO_CFG_RESET;
      end
      else
      begin
         cfg_q <= cfg_d & MFCO_CFG_MASK; // [RL9]
      end
   end

   // bus answer: one wait state, unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= req;
         dat_o <= 32'h0000_0000;
         if (req && !we_i)
         begin
            case (adr_i)
               MFCO_CFG_OFF, MFCO_CFG_CLR_OFF, MFCO_CFG_SET_OFF, MFCO_CFG_INV_OFF:
                  dat_o <= cfg_q & MFCO_CFG_MASK; // [RL9]
               MFCO_STAT_OFF: dat_o <= stat_q;
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // status: sticky bits cleared by writing one, set wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stat_q <= 32'h0000_0000;
      end
      else
      begin
         if (wr && (adr_i == MFCO_STAT_OFF))
         begin
            stat_q[MFCO_ST_ABORT_BIT] <= stat_q[MFCO_ST_ABORT_BIT] & ~(dat_i[0] & wmask[0]);
            stat_q[MFCO_ST_RXDROP_BIT] <= stat_q[MFCO_ST_RXDROP_BIT] & ~(dat_i[1] & wmask[1]);
         end
         if (abort_set)
         begin
            stat_q[MFCO_ST_ABORT_BIT] <= 1'b1; // [RL10]
         end
         if (rx_drop_int)
         begin
            stat_q[MFCO_ST_RXDROP_BIT] <= 1'b1;
         end
         stat_q[MFCO_ST_DEFER_BIT] <= (st_q == MFCO_TX_DEFER);
         stat_q[MFCO_ST_BACKOFF_BIT] <= (st_q == MFCO_TX_BACKOFF);
      end
   end

   assign abort_set = (st_q == MFCO_TX_DEFER) && carrier_i && !cfg_q[MFCO_DEFER_FOREVER_BIT]
                      && (dcnt_q == MFCO_DEFER_LIMIT_CYC);
   assign skip_now = cfg_q[MFCO_COL_SKIP_BIT] // [RL3]
                     || (cfg_q[MFCO_BP_SKIP_BIT] && backpressure_i); // [RL2]

   // pseudo-random source for backoff slots
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lfsr_q <= 10'h001;
      end
      else
      begin
         lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
      end
   end

   // transmit sequencer: defer, send, backoff
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= MFCO_TX_IDLE;
         dcnt_q <= 16'h0000;
         att_q <= 4'h0;
         slots_q <= 10'h000;
         scyc_q <= 8'h00;
         tx_go_o <= 1'b0;
         tx_abort_o <= 1'b0;
      end
      else
      begin
         tx_abort_o <= 1'b0;
         case (st_q)
            MFCO_TX_IDLE:
            begin
               dcnt_q <= 16'h0000;
               att_q <= 4'h0;
               if (tx_req_i)
               begin
                  st_q <= MFCO_TX_DEFER;
               end
            end
            MFCO_TX_DEFER:
            begin
               if (!carrier_i)
               begin
                  st_q <= MFCO_TX_SEND;
                  tx_go_o <= 1'b1;
                  dcnt_q <= 16'h0000;
               end
               else if (abort_set)
               begin
                  st_q <= MFCO_TX_IDLE; // [RL1]
                  tx_abort_o <= 1'b1; // [RL10]
               end
               else if (dcnt_q != MFCO_DEFER_LIMIT_CYC)
               begin
                  dcnt_q <= dcnt_q + 16'h0001; // [RL1]
               end
            end
            MFCO_TX_SEND:
            begin
               if (collision_i)
               begin
                  tx_go_o <= 1'b0;
                  if (skip_now)
                  begin
                     st_q <= MFCO_TX_DEFER; // [RL2] [RL3]
                  end
                  else
                  begin
                     st_q <= MFCO_TX_BACKOFF; // [RL3]
                     slots_q <= lfsr_q & ((10'h002 << att_q) - 10'h001);
                     scyc_q <= 8'(MFCO_SLOT_CYC - 1);
                     if (att_q != 4'(MFCO_BACKOFF_LIMIT - 1))
                     begin
                        att_q <= att_q + 4'h1;
                     end
                  end
               end
               else if (tx_done_i)
               begin
                  tx_go_o <= 1'b0;
                  st_q <= MFCO_TX_IDLE;
               end
            end
            MFCO_TX_BACKOFF:
            begin
               if (slots_q == 10'h000)
               begin
                  st_q <= MFCO_TX_DEFER;
               end
               else if (scyc_q == 8'h00)
               begin
                  scyc_q <= 8'(MFCO_SLOT_CYC - 1);
                  slots_q <= slots_q - 10'h001;
               end
               else
               begin
                  scyc_q <= scyc_q - 8'h01;
               end
            end
            default: st_q <= MFCO_TX_IDLE;
         endcase
      end
   end

   // tag detection on the two octets after the source address
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bcnt_q <= 5'h00;
         type_hi_q <= 8'h00;
         tagged_q <= 1'b0;
      end
      else if (tx_byte_valid_i)
      begin
         if (tx_first_i)
         begin
            bcnt_q <= 5'h01;
            tagged_q <= 1'b0;
         end
         else if (bcnt_q != 5'h1F)
         begin
            bcnt_q <= bcnt_q + 5'h01;
         end
         if (!tx_first_i && bcnt_q == MFCO_TYPE_POS)
         begin
            type_hi_q <= tx_byte_i;
         end
         if (!tx_first_i && bcnt_q == MFCO_TYPE_POS + 5'h01)
         begin
            tagged_q <= ({type_hi_q, tx_byte_i} == MFCO_TAG_ID); // [RL6]
         end
      end
   end

   // padding decision
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pad_on_o <= 1'b0;
         pad_min_len_o <= MFCO_MIN_UNTAGGED;
      end
      else
      begin
         pad_on_o <= cfg_q[MFCO_PAD_EN_BIT]; // [RL7]
         if (!cfg_q[MFCO_PAD_EN_BIT])
         begin
            pad_min_len_o <= MFCO_MIN_UNTAGGED; // [RL7]
         end
         else if (cfg_q[MFCO_AUTO_PAD_BIT])
         begin
            pad_min_len_o <= tagged_q ? MFCO_MIN_TAGGED : MFCO_MIN_UNTAGGED; // [RL6]
         end
         else if (cfg_q[MFCO_TAG_PAD_BIT])
         begin
            pad_min_len_o <= MFCO_MIN_TAGGED;
         end
         else
         begin
            pad_min_len_o <= MFCO_MIN_UNTAGGED;
         end
      end
   end

   // receive preamble checker
   mfco_rx_preamble u_rx_pre (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .short_pre_en_i(cfg_q[MFCO_SHORT_PRE_BIT]),
      .pure_pre_en_i(cfg_q[MFCO_PURE_PRE_BIT]),
      .rx_dv_i(rx_dv_i),
      .rx_er_i(rx_er_i),
      .rx_data_i(rx_data_i),
      .rx_accept_o(rx_acc_int),
      .rx_drop_o(rx_drop_int)
   );

   // verdicts re-registered at the top
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_accept_o <= 1'b0;
         rx_drop_o <= 1'b0;
      end
      else
      begin
         rx_accept_o <= rx_acc_int;
         rx_drop_o <= rx_drop_int;
      end
   end
endmodule

// file: dv/mfco_properties.sv
`timescale 1ns/1ps
module mfco_checker
   import mfco_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic carrier_i,
   input wire logic tx_go_o,
   input wire logic tx_abort_o,
   input wire logic [6:0] pad_min_len_o,
   input wire logic pad_on_o,
   input wire logic rx_dv_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_accept_o,
   input wire logic rx_drop_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // bus answer timing and idle data
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_dat_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
   property p_unimpl; ack_o |-> dat_o[31:15] == 17'h0 && dat_o[11:10] == 2'b00; endproperty
   a_unimpl: assert property (p_unimpl) else $error("unused bits set");
   // transmit deferral
   property p_abort; tx_abort_o |-> $past(carrier_i) && !tx_go_o; endproperty
   a_abort: assert property (p_abort) else $error("abort without carrier");
   property p_abort_pulse; tx_abort_o |=> !tx_abort_o; endproperty
   a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
   property p_go_start; $rose(tx_go_o) |-> !$past(carrier_i); endproperty
   a_go_start: assert property (p_go_start) else $error("sent over carrier");
   // receive verdicts
   property p_verdict;
      rx_accept_o || rx_drop_o |-> $past(rx_dv_i, 2) && $past(rx_data_i, 2) == MFCO_SFD_OCTET;
   endproperty
   a_verdict: assert property (p_verdict) else $error("verdict misplaced");
   property p_one_verdict; !(rx_accept_o && rx_drop_o); endproperty
   a_one_verdict: assert property (p_one_verdict) else $error("two verdicts");
   // padding
   property p_pad_off; !pad_on_o |-> pad_min_len_o == MFCO_MIN_UNTAGGED; endproperty
   a_pad_off: assert property (p_pad_off) else $error("pad length while off");
   property p_pad_len; pad_min_len_o == 7'h40 || pad_min_len_o == 7'h44; endproperty
   a_pad_len: assert property (p_pad_len) else $error("bad pad length");
endmodule
bind mfco_top mfco_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
   .carrier_i, .tx_go_o, .tx_abort_o, .pad_min_len_o, .pad_on_o, .rx_dv_i, .rx_data_i,
   .rx_accept_o, .rx_drop_o);

// file: dv/mfco_phy_model.sv
`timescale 1ns/1ps
module mfco_phy_model
   import mfco_pkg::*;
(
   input wire logic clk_i,
   output logic carrier_o,
   output logic collision_o,
   output logic rx_dv_o,
   output logic rx_er_o,
   output logic [7:0] rx_data_o
);
   // quiet link at start
   initial
   begin
      carrier_o = 1'b0;
      collision_o = 1'b0;
      rx_dv_o = 1'b0;
      rx_er_o = 1'b0;
      rx_data_o = 8'h00;
   end
   // preamble octets, start octet, then release with inverted data
   task automatic send(input int len, input logic [7:0] oct, input int er_at);
      for (int i = 0; i <= len; i++)
      begin
         @(posedge clk_i);
         rx_dv_o <= 1'b1;
         rx_er_o <= (i == er_at);
         rx_data_o <= (i == len) ? MFCO_SFD_OCTET : oct;
      end
      @(posedge clk_i);
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
      rx_data_o <= ~MFCO_SFD_OCTET;
   endtask
   task automatic carrier(input logic v);
      @(posedge clk_i);
      carrier_o <= v;
   endtask
   // one-cycle collision
   task automatic collide;
      @(posedge clk_i);
      collision_o <= 1'b1;
      @(posedge clk_i);
      collision_o <= 1'b0;
   endtask
endmodule

// file: dv/tb_mfco_top.sv
`timescale 1ns/1ps
module tb_mfco_top;
   import mfco_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic tx_req_i = 1'b0, tx_done_i = 1'b0, backpressure_i = 1'b0, tx_go_o, tx_abort_o;
   logic tx_byte_valid_i = 1'b0, tx_first_i = 1'b0, pad_on_o, h;
   logic [7:0] tx_byte_i = 8'h00, rx_data_i;
   logic [6:0] pad_min_len_o;
   logic carrier_i, collision_i, rx_dv_i, rx_er_i, rx_accept_o, rx_drop_o;
   int err_count = 0;
   int num_checks = 0;
   int wn = 0;
   mfco_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .tx_req_i(tx_req_i), .tx_done_i(tx_done_i), .carrier_i(carrier_i),
      .collision_i(collision_i), .backpressure_i(backpressure_i), .tx_go_o(tx_go_o),
      .tx_abort_o(tx_abort_o), .tx_byte_valid_i(tx_byte_valid_i), .tx_first_i(tx_first_i),
      .tx_byte_i(tx_byte_i), .pad_min_len_o(pad_min_len_o), .pad_on_o(pad_on_o),
      .rx_dv_i(rx_dv_i), .rx_er_i(rx_er_i), .rx_data_i(rx_data_i), .rx_accept_o(rx_accept_o),
      .rx_drop_o(rx_drop_o));
   mfco_phy_model phy (.clk_i(clk_i), .carrier_o(carrier_i), .collision_o(collision_i),
      .rx_dv_o(rx_dv_i), .rx_er_o(rx_er_i), .rx_data_o(rx_data_i));
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50)
      begin
         err_count++;
         $display("BAD bus ack exp 1 got 0");
         conclude();
      end
   endtask
   // bounded wait: 0 go high, 1 abort, 2 rx verdict, 3 go low
   task automatic await(input int k, input int lim);
      int n;
      n = 0;
      h = 1'b0;
      while (n < lim && !h)
      begin
         @(posedge clk_i);
         #1;
         n++;
         h = (k == 0) ? tx_go_o === 1'b1 : (k == 1) ? tx_abort_o === 1'b1 :
            (k == 2) ? (rx_accept_o | rx_drop_o) === 1'b1 : tx_go_o === 1'b0;
      end
      wn = n;
      if (!h)
      begin
         err_count++;
         $display("BAD wait kind %0d exp 1 got 0", k);
         conclude();
      end
   endtask
   task automatic padchk(input logic [31:0] exp);
      repeat (3) @(posedge clk_i);
      #1;
      chk("pad", exp, {24'h0, pad_on_o, pad_min_len_o});
   endtask
   // fourteen octets with the type field at 12 and 13
   task automatic txf(input logic [7:0] hi, input logic [7:0] lo);
      for (int i = 0; i < 14; i++)
      begin
         @(posedge clk_i);
         tx_byte_valid_i <= 1'b1;
         tx_first_i <= (i == 0);
         tx_byte_i <= (i == 12) ? hi : (i == 13) ? lo : 8'h11;
      end
      @(posedge clk_i);
      tx_byte_valid_i <= 1'b0;
   endtask
   task automatic rxc(input int len, input logic [7:0] oct, input int er, input logic acc);
      phy.send(len, oct, er);
      await(2, 6);
      chk("rx verdict", {30'h0, 1'b1, acc}, {30'h0, h, rx_accept_o});
   endtask
   // run watchdog
   initial
   begin
      #1000000;
      err_count++;
      conclude();
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, MFCO_CFG_OFF, 4'hF, 0);
      chk("cfg reset", 32'h0000_40B2, rd);
      chk("pad reset", 32'h0000_00C0, {24'h0, pad_on_o, pad_min_len_o});
      wb(1, MFCO_CFG_OFF, 4'hF, 32'hFFFF_FFFF);
      wb(1, MFCO_CFG_OFF, 4'h1, 32'h0000_0000);
      wb(0, MFCO_CFG_OFF, 4'hF, 0);
      chk("cfg mask", 32'h0000_73FF, rd);
      wb(1, MFCO_CFG_OFF, 4'h3, 32'h0000_0000);
      wb(1, MFCO_CFG_SET_OFF, 4'h0, 32'hFFFF_FFFF);
      wb(0, MFCO_CFG_OFF, 4'hF, 0);
      chk("cfg half clear", 32'h0000_0000, rd);
      wb(1, MFCO_CFG_SET_OFF, 4'h3, 32'h0000_1234);
      wb(1, MFCO_CFG_CLR_OFF, 4'hF, 32'h0000_0204);
      wb(1, MFCO_CFG_INV_OFF, 4'hC, 32'hFFFF_FFFF);
      wb(1, MFCO_CFG_INV_OFF, 4'hF, 32'h0000_0101);
      wb(0, MFCO_CFG_INV_OFF, 4'hF, 0);
      chk("cfg aliases", 32'h0000_1131, rd);
      // reset in mid-run brings back the power-on word
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, MFCO_CFG_OFF, 4'hF, 0);
      chk("cfg re-reset", MFCO_CFG_RESET, rd);
      $display("test registers done");
      // carrier held: defer without limit, then abort at the limit
      phy.carrier(1'b1);
      tx_req_i <= 1'b1;
      repeat (3200) @(posedge clk_i);
      wb(0, MFCO_STAT_OFF, 4'hF, 0);
      chk("stat deferring", 32'h0000_0004, rd);
      tx_req_i <= 1'b0;
      wb(1, MFCO_CFG_CLR_OFF, 4'hF, 32'h0000_4000);
      wb(0, MFCO_STAT_OFF, 4'hF, 0);
      chk("stat abort", 32'h0000_0001, rd);
      tx_req_i <= 1'b1;
      await(1, 3100);
      tx_req_i <= 1'b0;
      chk("abort cycles", 32'(MFCO_DEFER_LIMIT_CYC) + 32'd2, wn);
      wb(1, MFCO_STAT_OFF, 4'h3, 32'h0000_0001);
      wb(0, MFCO_STAT_OFF, 4'hF, 0);
      chk("stat clear", 32'h0000_0000, rd);
      $display("test deferral done");
      // collisions: normal backoff, skip bit, backpressure skip bit
      phy.carrier(1'b0);
      tx_req_i <= 1'b1;
      await(0, 4);
      tx_req_i <= 1'b0;
      phy.collide();
      #1;
      chk("go drop", 32'h0000_0000, {31'h0, tx_go_o});
      await(0, 400);
      chk("backoff gap", 32'h0000_0001, {31'h0, wn >= 2});
      wb(1, MFCO_CFG_SET_OFF, 4'hF, 32'h0000_1000);
      phy.collide();
      #1;
      await(0, 4);
      chk("skip gap", 32'h0000_0001, wn);
      wb(1, MFCO_CFG_INV_OFF, 4'hF, 32'h0000_3000);
      backpressure_i <= 1'b1;
      phy.collide();
      #1;
      await(0, 4);
      chk("bp skip gap", 32'h0000_0001, wn);
      backpressure_i <= 1'b0;
      phy.collide();
      #1;
      await(0, 600);
      chk("bp off gap", 32'h0000_0001, {31'h0, wn >= 2});
      tx_done_i <= 1'b1;
      await(3, 3);
      tx_done_i <= 1'b0;
      $display("test collisions done");
      // receive preamble length and content checks
      wb(1, MFCO_CFG_SET_OFF, 4'h3, 32'h0000_0300);
      rxc(7, 8'h55, -1, 1'b1);
      rxc(11, 8'h55, -1, 1'b1);
      rxc(12, 8'h55, -1, 1'b0);
      rxc(7, 8'h57, -1, 1'b0);
      rxc(7, 8'h55, 3, 1'b0);
      rxc(7, 8'h55, 7, 1'b0);
      wb(0, MFCO_STAT_OFF, 4'hF, 0);
      chk("stat rx drop", 32'h0000_0002, rd);
      wb(1, MFCO_CFG_CLR_OFF, 4'h3, 32'h0000_0300);
      rxc(12, 8'h57, 2, 1'b1);
      $display("test receive done");
      // padding: auto detect on tagged and untagged frames, then overrides
      txf(8'h81, 8'h00);
      padchk(32'h0000_00C4);
      txf(8'h08, 8'h00);
      padchk(32'h0000_00C0);
      wb(1, MFCO_CFG_INV_OFF, 4'h3, 32'h0000_00C0);
      padchk(32'h0000_00C4);
      wb(1, MFCO_CFG_INV_OFF, 4'h3, 32'h0000_00A0);
      txf(8'h81, 8'h00);
      padchk(32'h0000_0040);
      $display("test padding done");
      conclude();
   end
endmodule
